// ### scr_pkg.sv
// Package: register map, field layout, reset values and decoded types for the config bank
package scr_pkg;
	// Register indices (printed offsets are not multiples of four)
	localparam logic [7:0] RSVD_FIRST_IDX = 8'h08;
	localparam logic [7:0] RSVD_LAST_IDX = 8'h0A;
	localparam logic [7:0] ANALOG_CONFIG_IDX = 8'h0B;
	localparam logic [7:0] DIGITAL_CONFIG_IDX = 8'h0C;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned ADDR_LSB = 2;

	// Reset values
	localparam logic [7:0] RSVD_VALUE = 8'h00;
	localparam logic [7:0] ANALOG_CONFIG_RST = 8'h60;
	localparam logic [7:0] DIGITAL_CONFIG_RST = 8'h3C;

	// Analog config fields
	localparam int unsigned A_PUMP_BIT = 7;
	localparam int unsigned A_HIRES_BIT = 6;
	localparam int unsigned A_KEEP1_BIT = 5;
	localparam int unsigned A_REFLVL_BIT = 4;
	localparam int unsigned A_INTREF_BIT = 3;
	localparam int unsigned A_THR_LSB = 0;
	localparam int unsigned A_THR_W = 3;

	// Digital config fields
	localparam int unsigned D_WDOG_BIT = 7;
	localparam int unsigned D_CRCALL_BIT = 6;
	localparam int unsigned D_DONE_LSB = 4;
	localparam int unsigned D_FLOAT_LSB = 2;
	localparam int unsigned D_DLY_W = 2;
	localparam int unsigned D_FIXED_BIT = 1;
	localparam int unsigned D_CRCEN_BIT = 0;

	// Delay codes pick a least time in ns; cycles derived at 100 MHz
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned DLY_BASE_NS = 6;
	localparam int unsigned DLY_STEP_NS = 2;

	// Comparator thresholds, in tenths of a percent
	localparam int unsigned THR_PERMIL_HI [8] = '{950, 925, 900, 875, 850, 800, 750, 700};

	// Fixed frame sizes
	localparam int unsigned FIXED_WORDS_4CH = 6;
	localparam int unsigned FIXED_WORDS_2CH = 4;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic neg_pump_enable;
		logic high_res_select;
		logic ref_level_select;
		logic internal_ref_select;
		logic [2:0] fault_comparator_threshold;
		logic low_thr_from_pump;
		logic [9:0] high_thr_permil;
		logic [9:0] low_thr_permil;
	} scr_analog_s;

	typedef struct packed {
		logic watchdog_enable;
		logic crc_all_bits;
		logic [1:0] done_delay;
		logic [1:0] output_float_delay;
		logic [3:0] done_delay_cycles;
		logic [3:0] float_delay_cycles;
		logic fixed_frame;
		logic crc_enable;
		logic [3:0] fixed_frame_words;
	} scr_digital_s;
endpackage

// ### scr_delay_map.sv
// Delay code to least-cycle count converter
`timescale 1ns/1ps
`default_nettype none
module scr_delay_map (
	input wire logic [1:0] code,
	output logic [3:0] ns,
	output logic [3:0] cycles
);
	wire [31:0] ns_full;
	wire [31:0] cyc_full;
	assign ns_full = scr_pkg::DLY_BASE_NS + scr_pkg::DLY_STEP_NS * 32'(code);
	// Least time: round up, never below one cycle
	assign cyc_full = (ns_full + scr_pkg::CLK_PERIOD_NS - 1) / scr_pkg::CLK_PERIOD_NS;
	assign ns = ns_full[3:0];
	assign cycles = (cyc_full == 32'h0000_0000) ? 4'h1 : cyc_full[3:0];
endmodule
`default_nettype wire

// ### scr_config_regs.sv
// AXI4-Lite system configuration bank: reserved words, analog and digital config
// Operation
// - Indices 08h-0Ah are reserved, read only, always read zero.
// - Analog config at index 0Bh resets to 60h.
// - Analog bit 7 enables negative charge pump; clear powers it down.
// - Analog bit 6: 0 low-power, 1 high-resolution; resets to 1.
// - Analog bit 4 picks internal positive reference level: 2.442 V or 4.0 V.
// - Analog bit 3: 0 external reference, 1 internal reference to buffer.
// - Bits 2:0 map comparator thresholds 95/5 down to 70/30 percent.
// - Pump off: rails reference thresholds; pump on: low uses pump output.
// - Digital config at index 0Ch resets to 3Ch.
// - Digital bit 7 enables watchdog counter; resets disabled.
// - Digital bit 6: CRC over device words only, or whole frame.
// - Bits 5:4 pick least done delay 6, 8, 10, 12 ns; reset 11.
// - Bits 3:2 pick least output float delay 6 to 12 ns; reset 11.
// - Bit 1 fixes frame words: six or four, else varies with enables.
// - Bit 0 adds CRC word to input and output frames; reset off.
// - With CRC on, commands failing CRC are ignored; host supplies CRC. cmd_reject is formed here but never output.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module scr_config_regs #(
	parameter bit FOUR_CHANNEL = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cmd_crc_fail,
	output scr_pkg::scr_analog_s analog_out,
	output scr_pkg::scr_digital_s digital_out
);
	typedef enum logic [1:0] {
		SCR_IDLE = 2'b00,
		SCR_RESP = 2'b01
	} scr_wstate_e;

	// Register index from a byte address, or 8'hFF if not word aligned
	function automatic logic [7:0] scr_index(input logic [7:0] addr);
		scr_index = (addr[1:0] == 2'b00) ? {2'b00, addr[7:2]} : 8'hFF;
	endfunction

	function automatic logic scr_mapped(input logic [7:0] idx);
		scr_mapped = (idx >= scr_pkg::RSVD_FIRST_IDX) && (idx <= scr_pkg::DIGITAL_CONFIG_IDX);
	endfunction

	logic [7:0] analog_q;
	logic [7:0] analog_d;
	logic [7:0] digital_q;
	logic [7:0] digital_d;
	logic [7:0] awaddr_q;
	logic aw_have_q;
	logic [7:0] wdata_q;
	logic w_strb0_q;
	logic w_have_q;
	scr_wstate_e wstate_q;
	logic [1:0] bresp_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic rvalid_q;

	wire aw_take = s_axi_awvalid && !aw_have_q && (wstate_q == SCR_IDLE);
	wire w_take = s_axi_wvalid && !w_have_q && (wstate_q == SCR_IDLE);
	wire ar_take = s_axi_arvalid && !rvalid_q;
	wire [7:0] aw_cur = aw_take ? s_axi_awaddr : awaddr_q;
	wire [7:0] w_cur = w_take ? s_axi_wdata[7:0] : wdata_q;
	wire strb_cur = w_take ? s_axi_wstrb[0] : w_strb0_q;
	wire aw_ok = aw_take || aw_have_q;
	wire w_ok = w_take || w_have_q;
	wire do_write = aw_ok && w_ok && (wstate_q == SCR_IDLE);
	wire [7:0] widx = scr_index(aw_cur);
	wire [7:0] ridx = scr_index(s_axi_araddr);
	wire wr_mapped = scr_mapped(widx);
	// Byte lane 0 carries the whole 8-bit register
	wire wr_analog = do_write && strb_cur && (widx == scr_pkg::ANALOG_CONFIG_IDX);
	wire wr_digital = do_write && strb_cur && (widx == scr_pkg::DIGITAL_CONFIG_IDX);

	wire [7:0] rd_byte = (ridx == scr_pkg::ANALOG_CONFIG_IDX) ? analog_q :
		(ridx == scr_pkg::DIGITAL_CONFIG_IDX) ? digital_q : scr_pkg::RSVD_VALUE;
	wire rd_mapped = scr_mapped(ridx);

	assign analog_d = wr_analog ? w_cur : analog_q;
	assign digital_d = wr_digital ? w_cur : digital_q;

	assign s_axi_awready = (wstate_q == SCR_IDLE) && !aw_have_q;
	assign s_axi_wready = (wstate_q == SCR_IDLE) && !w_have_q;
	assign s_axi_bvalid = (wstate_q == SCR_RESP);
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			analog_q <= scr_pkg::ANALOG_CONFIG_RST;
			digital_q <= scr_pkg::DIGITAL_CONFIG_RST;
		end
		else
		begin
			analog_q <= analog_d;
			digital_q <= digital_d;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 8'h00;
			w_strb0_q <= 1'b0;
			wstate_q <= SCR_IDLE;
			bresp_q <= scr_pkg::RESP_OKAY;
		end
		else
		begin
			case (wstate_q)
				SCR_IDLE:
				begin
					if (do_write)
					begin
						aw_have_q <= 1'b0;
						w_have_q <= 1'b0;
						wstate_q <= SCR_RESP;
						bresp_q <= wr_mapped ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR;
					end
					else
					begin
						if (aw_take)
						begin
							aw_have_q <= 1'b1;
							awaddr_q <= s_axi_awaddr;
						end
						if (w_take)
						begin
							w_have_q <= 1'b1;
							wdata_q <= s_axi_wdata[7:0];
							w_strb0_q <= s_axi_wstrb[0];
						end
					end
				end
				SCR_RESP:
				begin
					if (s_axi_bready)
					begin
						wstate_q <= SCR_IDLE;
					end
				end
				default:
				begin
					wstate_q <= SCR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= scr_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h00_0000, rd_byte};
			rresp_q <= rd_mapped ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			rvalid_q <= 1'b0;
		end
	end

	// Decoded analog controls, driven from the register flops
	wire [2:0] thr_code = analog_q[scr_pkg::A_THR_LSB +: scr_pkg::A_THR_W];
	wire [31:0] thr_hi_full = scr_pkg::THR_PERMIL_HI[thr_code];
	always_comb
	begin
		analog_out.neg_pump_enable = analog_q[scr_pkg::A_PUMP_BIT];
		analog_out.high_res_select = analog_q[scr_pkg::A_HIRES_BIT];
		analog_out.ref_level_select = analog_q[scr_pkg::A_REFLVL_BIT];
		analog_out.internal_ref_select = analog_q[scr_pkg::A_INTREF_BIT];
		analog_out.fault_comparator_threshold = thr_code;
		analog_out.high_thr_permil = thr_hi_full[9:0];
		analog_out.low_thr_permil = 10'(32'd1000 - thr_hi_full);
		analog_out.low_thr_from_pump = analog_q[scr_pkg::A_PUMP_BIT];
	end

	logic [3:0] done_cyc;
	logic [3:0] float_cyc;
	scr_delay_map u_done_map (
		.code(digital_q[scr_pkg::D_DONE_LSB +: scr_pkg::D_DLY_W]),
		.ns(),
		.cycles(done_cyc)
	);
	scr_delay_map u_float_map (
		.code(digital_q[scr_pkg::D_FLOAT_LSB +: scr_pkg::D_DLY_W]),
		.ns(),
		.cycles(float_cyc)
	);

	always_comb
	begin
		digital_out.watchdog_enable = digital_q[scr_pkg::D_WDOG_BIT];
		digital_out.crc_all_bits = digital_q[scr_pkg::D_CRCALL_BIT];
		digital_out.done_delay = digital_q[scr_pkg::D_DONE_LSB +: scr_pkg::D_DLY_W];
		digital_out.output_float_delay = digital_q[scr_pkg::D_FLOAT_LSB +: scr_pkg::D_DLY_W];
		digital_out.done_delay_cycles = done_cyc;
		digital_out.float_delay_cycles = float_cyc;
		digital_out.fixed_frame = digital_q[scr_pkg::D_FIXED_BIT];
		digital_out.fixed_frame_words = FOUR_CHANNEL ? 4'(scr_pkg::FIXED_WORDS_4CH)
			: 4'(scr_pkg::FIXED_WORDS_2CH);
		// CRC word enable; qualifies crc fail input below
		digital_out.crc_enable = digital_q[scr_pkg::D_CRCEN_BIT];
	end

	// Not brought out of the bank; only feeds unused_ok
	// reject bad CRC
	wire cmd_reject = digital_q[scr_pkg::D_CRCEN_BIT] && cmd_crc_fail;
	wire unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1],
		cmd_reject};
endmodule
`default_nettype wire

// ### scr_cfg_asserts.sv
// Checker for the config bank: bus handshakes and decoded outputs
`timescale 1ns/1ps
`default_nettype none
module scr_cfg_asserts #(
	parameter bit FOUR_CHANNEL = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire scr_pkg::scr_analog_s analog_out,
	input wire scr_pkg::scr_digital_s digital_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (wr_take |=> s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read data missing");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data not held");
	a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_rsvd_zero: assert property (
		(rd_take and s_axi_araddr inside {8'h20, 8'h24, 8'h28}) |=> s_axi_rdata == 32'h0000_0000)
		else $error("reserved word not zero");
	// Data may be taken before the address, so only the response start marks a write
	a_cfg_quiet: assert property (!$rose(s_axi_bvalid) |-> $stable(analog_out) && $stable(digital_out))
		else $error("config changed without write");
	a_pump_low_ref: assert property (analog_out.low_thr_from_pump == analog_out.neg_pump_enable)
		else $error("low threshold reference wrong");
	a_thr_split: assert property (
		analog_out.high_thr_permil + analog_out.low_thr_permil == 10'h3E8)
		else $error("thresholds not symmetric");
	a_done_cycles: assert property (
		digital_out.done_delay_cycles == (digital_out.done_delay == 2'h3 ? 4'h2 : 4'h1))
		else $error("done delay cycles wrong");
	a_float_cycles: assert property (
		digital_out.float_delay_cycles == (digital_out.output_float_delay == 2'h3 ? 4'h2 : 4'h1))
		else $error("float delay cycles wrong");
	a_fixed_words: assert property (
		digital_out.fixed_frame_words == (FOUR_CHANNEL ? 4'h6 : 4'h4))
		else $error("fixed frame size wrong");
endmodule
bind scr_config_regs scr_cfg_asserts #(.FOUR_CHANNEL(FOUR_CHANNEL)) u_chk (.*);
`default_nettype wire

// ### scr_host_model.sv
// Register-bus host issuing single writes and reads
`timescale 1ns/1ps
`default_nettype none
module scr_host_model (
	input wire logic aclk,
	output logic [7:0] s_axi_awaddr = 8'h00,
	output logic s_axi_awvalid = 1'b0,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata = 32'h0000_0000,
	output logic [3:0] s_axi_wstrb = 4'h0,
	output logic s_axi_wvalid = 1'b0,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready = 1'b1,
	output logic [7:0] s_axi_araddr = 8'h00,
	output logic s_axi_arvalid = 1'b0,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		// Released lines show the inverse so stale values cannot pass
		s_axi_awaddr <= ~a;
		s_axi_wdata <= ~d;
	endtask
	// A slow host delays rready so the slave must hold its answer
	task automatic rd(input logic [7:0] a, input int dl, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
			@(posedge aclk);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		repeat (dl) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do
			@(posedge aclk);
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the config bank against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk, aresetn, cmd_crc_fail;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	scr_pkg::scr_analog_s analog_out;
	scr_pkg::scr_digital_s digital_out;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	int an_m, dg_m;
	int thr[8] = '{950, 925, 900, 875, 850, 800, 750, 700};
	logic [7:0] addr_tab[7] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h2D};
	scr_config_regs #(.FOUR_CHANNEL(1'b1)) DUT (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0));
	scr_host_model host (.*);
	initial
	begin
		aclk = 1'b0;
		forever
			#5 aclk = ~aclk;
	end
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_total++;
			final_report();
		end
	end
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
		chk_val({30'h0, g}, {30'h0, e});
	endtask
	task automatic check_dec();
		logic [27:0] ea;
		logic [19:0] ed;
		int t;
		t = thr[an_m[2:0]];
		ea = {an_m[7], an_m[6], an_m[4], an_m[3], an_m[2:0], an_m[7], t[9:0], 10'(1000 - t)};
		ed = {dg_m[7:2], 4'((15 + 2 * dg_m[5:4]) / 10), 4'((15 + 2 * dg_m[3:2]) / 10),
			dg_m[1:0], 4'h6};
		chk_val(32'(analog_out), 32'(ea));
		chk_val(32'(digital_out), 32'(ed));
	endtask
	task automatic access(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] r;
		logic [31:0] q;
		logic ok;
		ok = a[1:0] == 2'h0 && a[7:2] inside {[6'h08:6'h0C]};
		// frame checks stay outside this bank; the flag just toggles
		cmd_crc_fail <= 1'($urandom);
		host.wr(a, d, s, r);
		chk_rsp(r, ok ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR);
		if (s[0] && a == 8'h2C)
			an_m = d[7:0];
		if (s[0] && a == 8'h30)
			dg_m = d[7:0];
		check_dec();
		host.rd(a, $urandom_range(3), q, r);
		chk_rsp(r, ok ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR);
		chk_val(q, a == 8'h2C ? 32'(an_m) : a == 8'h30 ? 32'(dg_m) : 32'h0000_0000);
	endtask
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		an_m = 'h60;
		dg_m = 'h3C;
		foreach (addr_tab[k])
			access(addr_tab[k], $urandom, 4'h0);
	endtask
	initial
	begin
		logic [31:0] d;
		void'($urandom(32));
		cmd_crc_fail = 1'b0;
		aresetn = 1'b0;
		@(posedge aclk);
		do_reset();
		for (int i = 0; i < 70; i++)
		begin
			d = $urandom;
			d[2:0] = 3'(i / 7);
			access(addr_tab[i % 7], d, 4'($urandom) | {3'h0, i[0]});
		end
		// host resets after the watchdog may have been enabled
		do_reset();
		final_report();
	end
endmodule
`default_nettype wire
